// file: hdl/swt_top.v
// How it works
// [RULE1] Two independent wake timers, zero and one, each a 41-bit counter.
// [RULE2] Timers step on the slow clock, whether the device sleeps or runs.
// [RULE3] A started timer counts down and signals the system controller at zero.
// [RULE4] A per-timer enable gates the zero-reached interrupt.
// [RULE5] Software gives start values in slow periods; thirty-two is one millisecond.
// [RULE6] At zero a timer reloads the 33-bit all-ones wrap value and keeps counting.
// [RULE7] Stop freezes the count and suppresses the interrupt.
// [RULE8] The live count is always readable without disturbing the timer.
// [RULE9] A running flag per timer shows which timers are counting.
// [RULE10] A fired flag per timer shows a zero pass; reading it clears it.
// [RULE11] The interrupt goes out on the system controller path, no own line.
// [RULE12] Software stops timer zero and clears fired flags before calibrating.
// [RULE13] Calibration: timer zero counts twenty periods, reference counter counts fast clock.
// [RULE14] At timer zero reaching zero the reference count is published.
// [RULE15] An enhanced calibration lets software choose the number of slow periods.
// [RULE16] Fired sets on every zero pass regardless of enable, held until read.
`timescale 1ns/1ps
`include "swt_defs.vh"

module swt_top #(
	parameter CNT_W = `SWT_CNT_W,
	parameter REF_W = `SWT_REF_W,
	parameter PER_W = `SWT_CAL_PER_W
) (
	input  wire             core_clk,        // Core clock, 250 MHz.
	input  wire             rst_n,           // Asynchronous reset, active low.
	input  wire             lp_clk,          // Slow 32 kHz clock, sampled as data.
	input  wire             ref_clk,         // 16 MHz peripheral clock, sampled as data.
	input  wire             wt0_start,       // Pulse: start timer zero.
	input  wire [CNT_W-1:0] wt0_load,        // Timer zero start value.
	input  wire             wt0_stop,        // Pulse: stop timer zero.
	input  wire             wt0_int_en,      // Timer zero interrupt enable.
	input  wire             wt1_start,       // Pulse: start timer one.
	input  wire [CNT_W-1:0] wt1_load,        // Timer one start value.
	input  wire             wt1_stop,        // Pulse: stop timer one.
	input  wire             wt1_int_en,      // Timer one interrupt enable.
	input  wire             fired_rd,        // Pulse: read and clear fired flags.
	input  wire             cal_start,       // Pulse: begin a calibration.
	input  wire [PER_W-1:0] cal_periods,     // Calibration periods, zero means default.
	output wire [CNT_W-1:0] wt0_count,       // Live count of timer zero.
	output wire [CNT_W-1:0] wt1_count,       // Live count of timer one.
	output wire [1:0]       wt_running,      // Running flags, bit per timer.
	output reg  [1:0]       wt_fired_q,      // Fired flags, bit per timer.
	output reg  [1:0]       sysctl_irq_q,    // Pulse per timer toward system controller.
	output reg              cal_busy_q,      // Calibration in progress.
	output wire             cal_done,        // Pulse: cal_result updated.
	output reg              cal_refused_q,   // Pulse: calibration start refused.
	output wire [REF_W-1:0] cal_result       // Reference count of last calibration.
);

	// Rising-edge test shared by both sampled clocks.
	function swt_rise;
		input cur;
		input prev;
		begin
			swt_rise = cur & ~prev;
		end
	endfunction

	reg             lp_prev_q;
	reg             ref_prev_q;
	wire            lp_tick;
	wire            ref_tick;
	reg  [1:0]      cal_st_q;
	reg  [1:0]      cal_st_d;
	reg  [PER_W-1:0] cal_per_q;
	wire            cal_load;
	wire            cal_abort;
	wire            t0_start;
	wire [CNT_W-1:0] t0_val;
	wire            t0_run;
	wire            t1_run;
	wire            t0_fire;
	wire            t1_fire;
	wire [1:0]      fire_vec;
	wire [1:0]      en_vec;

	// Edge history of the sampled clocks; inputs are already core-synchronous.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_prev_q  <= 1'b0;
			ref_prev_q <= 1'b0;
		end else begin
			lp_prev_q  <= lp_clk;
			ref_prev_q <= ref_clk;
		end
	end

	// No sleep input gates the tick: the timers count in every power state.
	assign lp_tick  = swt_rise(lp_clk, lp_prev_q); // [RULE2]
	assign ref_tick = swt_rise(ref_clk, ref_prev_q);

	// Calibration owns timer zero's start path while it loads the count.
	assign cal_load = (cal_st_q == `SWT_CAL_ARM) && lp_tick;
	assign t0_start = cal_load | (wt0_start & ~cal_busy_q);
	assign t0_val   = cal_load ? {{(CNT_W-PER_W){1'b0}}, cal_per_q} : wt0_load; // [RULE15]

	// Timer zero.
	swt_wake_ctr #(
		.CNT_W    (CNT_W)
	) u_wt0 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.lp_tick  (lp_tick),
		.start    (t0_start),
		.load_val (t0_val),
		.stop     (wt0_stop),
		.cnt_q    (wt0_count),
		.run_q    (t0_run),
		.fire_q   (t0_fire)
	); // [RULE1]

	// Timer one.
	swt_wake_ctr #(
		.CNT_W    (CNT_W)
	) u_wt1 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.lp_tick  (lp_tick),
		.start    (wt1_start),
		.load_val (wt1_load),
		.stop     (wt1_stop),
		.cnt_q    (wt1_count),
		.run_q    (t1_run),
		.fire_q   (t1_fire)
	); // [RULE1]

	// Counts and run flags are wired straight out; reading never touches them.
	assign wt_running = {t1_run, t0_run}; // [RULE8] [RULE9]

	assign fire_vec = {t1_fire, t0_fire};
	assign en_vec   = {wt1_int_en, wt0_int_en};

	// Fired flags: a fire landing in the read-clear cycle survives the clear.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wt_fired_q <= 2'h0;
		end else begin
			wt_fired_q <= (wt_fired_q & {2{~fired_rd}}) | fire_vec; // [RULE10] [RULE16]
		end
	end

	// Interrupt pulses go to the system controller's aggregator only.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysctl_irq_q <= 2'h0;
		end else begin
			sysctl_irq_q <= fire_vec & en_vec; // [RULE4] [RULE11]
		end
	end

	// A user stop of timer zero during a measurement abandons it.
	assign cal_abort = (cal_st_q == `SWT_CAL_RUN) && !t0_run && !t0_fire;

	// Calibration sequencer. Arming waits for a slow-clock edge so whole periods
	// are measured; the reference count starts in the same cycle as the load.
	always @* begin
		cal_st_d = cal_st_q;
		case (cal_st_q)
			`SWT_CAL_IDLE: begin
				if (cal_start && !t0_run) begin
					cal_st_d = `SWT_CAL_ARM;
				end
			end
			`SWT_CAL_ARM: begin
				if (wt0_stop) begin
					cal_st_d = `SWT_CAL_IDLE;
				end else if (lp_tick) begin
					cal_st_d = `SWT_CAL_RUN; // [RULE13]
				end
			end
			`SWT_CAL_RUN: begin
				if (t0_fire || cal_abort) begin
					cal_st_d = `SWT_CAL_IDLE; // [RULE14]
				end
			end
			default: begin
				cal_st_d = `SWT_CAL_IDLE;
			end
		endcase
	end

	// Sequencer registers; the period count is latched at the start request.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_st_q      <= `SWT_CAL_IDLE;
			cal_per_q     <= `SWT_CAL_DEF_PER;
			cal_busy_q    <= 1'b0;
			cal_refused_q <= 1'b0;
		end else begin
			cal_st_q      <= cal_st_d;
			cal_busy_q    <= (cal_st_d != `SWT_CAL_IDLE);
			// Start while timer zero runs is the caller's fault; refuse it visibly.
			cal_refused_q <= cal_start && (t0_run || cal_st_q != `SWT_CAL_IDLE); // [RULE12]
			if (cal_start && cal_st_q == `SWT_CAL_IDLE && !t0_run) begin
				if (cal_periods == {PER_W{1'b0}}) begin
					cal_per_q <= `SWT_CAL_DEF_PER; // [RULE13]
				end else begin
					cal_per_q <= cal_periods; // [RULE15]
				end
			end
		end
	end

	// Reference counter on the fast peripheral clock.
	swt_cal_ref #(
		.REF_W    (REF_W)
	) u_ref (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (cal_load),
		.ref_tick (ref_tick),
		.capture  (t0_fire && cal_st_q == `SWT_CAL_RUN),
		.abort    (cal_abort || (cal_st_q == `SWT_CAL_ARM && wt0_stop)),
		.result_q (cal_result),
		.done_q   (cal_done)
	); // [RULE13] [RULE14]

endmodule

// file: hdl/swt_defs.vh
`ifndef SWT_DEFS_VH
`define SWT_DEFS_VH

// Counter geometry.
`define SWT_CNT_W          41
`define SWT_REF_W          32
`define SWT_CAL_PER_W      16

// Value taken on when a timer passes zero.
`define SWT_WRAP_VAL       41'h001_ffff_ffff

// Reset values.
`define SWT_CNT_RST        41'h000_0000_0000
`define SWT_REF_RST        32'h0000_0000

// Calibration defaults and nominal figures.
`define SWT_CAL_DEF_PER    16'h0014
`define SWT_CAL_NOM_REF    32'h0000_2710

// Clock rates in hertz.
`define SWT_CORE_CLK_HZ    250000000
`define SWT_LP_CLK_HZ      32000
`define SWT_REF_CLK_HZ     16000000

// Calibration sequencer state codes.
`define SWT_CAL_IDLE       2'h0
`define SWT_CAL_ARM        2'h1
`define SWT_CAL_RUN        2'h2

`endif

// file: hdl/swt_wake_ctr.v
`timescale 1ns/1ps
`include "swt_defs.vh"

module swt_wake_ctr #(
	parameter CNT_W = `SWT_CNT_W
) (
	input  wire             core_clk,  // Core clock.
	input  wire             rst_n,     // Asynchronous reset, active low.
	input  wire             lp_tick,   // One-cycle pulse per slow-clock period.
	input  wire             start,     // Load value and start counting.
	input  wire [CNT_W-1:0] load_val,  // Countdown start value.
	input  wire             stop,      // Freeze the count.
	output reg  [CNT_W-1:0] cnt_q,     // Live count.
	output reg              run_q,     // Timer is counting.
	output reg              fire_q     // One-cycle pulse on reaching zero.
);

	reg [CNT_W-1:0] cnt_d;
	reg             run_d;
	reg             fire_d;

	// Stop takes priority over start so a frozen timer never fires late.
	always @* begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		fire_d = 1'b0;
		if (stop) begin
			run_d = 1'b0; // [RULE7]
		end else if (start) begin
			cnt_d = load_val;
			run_d = 1'b1;
		end else if (run_q && lp_tick) begin
			// A zero start value fires on the first period.
			if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1} || cnt_q == {CNT_W{1'b0}}) begin
				cnt_d  = `SWT_WRAP_VAL; // [RULE6]
				fire_d = 1'b1; // [RULE3]
			end else begin
				cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE3]
			end
		end
	end

	// State registers.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= `SWT_CNT_RST;
			run_q  <= 1'b0;
			fire_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			fire_q <= fire_d;
		end
	end

endmodule

// file: hdl/swt_cal_ref.v
`timescale 1ns/1ps
`include "swt_defs.vh"

module swt_cal_ref #(
	parameter REF_W = `SWT_REF_W
) (
	input  wire             core_clk,  // Core clock.
	input  wire             rst_n,     // Asynchronous reset, active low.
	input  wire             clear,     // Restart the count from zero and enable it.
	input  wire             ref_tick,  // One-cycle pulse per reference-clock period.
	input  wire             capture,   // Freeze and publish the count.
	input  wire             abort,     // Stop counting without publishing.
	output reg  [REF_W-1:0] result_q,  // Last published reference count.
	output reg              done_q     // One-cycle pulse when result_q updates.
);

	reg [REF_W-1:0] acc_q;
	reg             en_q;

	// The counter saturates rather than wrapping, so a stalled slow clock
	// gives an obviously large result instead of a small wrong one.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q    <= `SWT_REF_RST;
			en_q     <= 1'b0;
			result_q <= `SWT_REF_RST;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (clear) begin
				acc_q <= `SWT_REF_RST; // [RULE13]
				en_q  <= 1'b1;
			end else if (capture && en_q) begin
				result_q <= acc_q + {{(REF_W-1){1'b0}}, ref_tick}; // [RULE14]
				done_q   <= 1'b1;
				en_q     <= 1'b0;
			end else if (abort) begin
				en_q <= 1'b0;
			end else if (en_q && ref_tick && acc_q != {REF_W{1'b1}}) begin
				acc_q <= acc_q + {{(REF_W-1){1'b0}}, 1'b1}; // [RULE13]
			end
		end
	end

endmodule

// file: verif/swt_props.sv
`timescale 1ns/1ps
`include "swt_defs.vh"

module swt_props #(
	parameter CNT_W = `SWT_CNT_W
) (
	input wire             core_clk,      // Clock.
	input wire             rst_n,         // Reset.
	input wire             lp_clk,        // Slow clock.
	input wire             wt0_start,     // Start zero.
	input wire             wt0_stop,      // Stop zero.
	input wire             wt0_int_en,    // Enable zero.
	input wire             wt1_start,     // Start one.
	input wire [CNT_W-1:0] wt1_load,      // Load one.
	input wire             wt1_stop,      // Stop one.
	input wire             wt1_int_en,    // Enable one.
	input wire             fired_rd,      // Fired read.
	input wire             cal_start,     // Calibrate.
	input wire [CNT_W-1:0] wt0_count,     // Count zero.
	input wire [CNT_W-1:0] wt1_count,     // Count one.
	input wire [1:0]       wt_running,    // Running.
	input wire [1:0]       wt_fired_q,    // Fired.
	input wire [1:0]       sysctl_irq_q,  // Interrupts.
	input wire             cal_busy_q,    // Busy.
	input wire             cal_done,      // Done.
	input wire             cal_refused_q  // Refused.
);
	reg              lp_prev_q;
	wire             tick;
	wire [CNT_W-1:0] wrap;

	// Edge history mirrors the design, so a high level at release counts as a tick.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			lp_prev_q <= 1'b0;
		else
			lp_prev_q <= lp_clk;
	end
	assign tick = lp_clk & ~lp_prev_q;
	assign wrap = `SWT_WRAP_VAL;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	load_start_a: assert property (wt1_start && !wt1_stop |=>
		wt1_count == $past(wt1_load) && wt_running[1]) else $error("timer one failed to load");
	count_down_a: assert property (tick && wt_running[0] && wt0_count > 41'h1
		&& !wt0_start && !wt0_stop |=> wt0_count == $past(wt0_count) - 41'h1)
		else $error("timer zero failed to decrement");
	// The count wraps one edge after the tick; flag and interrupt follow one edge later.
	wrap_fire_a: assert property (tick && wt_running[1] && wt1_count <= 41'h1
		&& !wt1_start && !wt1_stop |=> wt1_count == wrap && wt_running[1]
		##1 wt_fired_q[1] && sysctl_irq_q[1] == $past(wt1_int_en))
		else $error("timer one bad zero pass");
	irq_gate_a: assert property (sysctl_irq_q != 2'h0 |->
		(!sysctl_irq_q[0] || ($past(wt0_int_en) && wt_fired_q[0]))
		&& (!sysctl_irq_q[1] || ($past(wt1_int_en) && wt_fired_q[1])))
		else $error("timer interrupt not gated");
	stop_hold_a: assert property (wt0_stop |=> !wt_running[0]
		&& wt0_count == $past(wt0_count) && !sysctl_irq_q[0]) else $error("stop did not freeze");
	idle_hold_a: assert property (!wt_running[1] && !wt1_start |=>
		$stable(wt1_count) && !sysctl_irq_q[1]) else $error("idle timer one moved");
	// A tick one edge earlier can fire in the clear cycle, and the set wins.
	fired_clear_a: assert property (fired_rd && !$past(tick) |=> wt_fired_q == 2'h0)
		else $error("fired flags not cleared");
	fired_keep_a: assert property (wt_fired_q[0] && !fired_rd |=> wt_fired_q[0])
		else $error("fired flag lost");
	cal_arm_a: assert property (cal_start && !cal_busy_q && !wt_running[0] && !wt0_stop
		|=> cal_busy_q) else $error("calibration not armed");
	cal_done_a: assert property (cal_done |-> !cal_busy_q && wt_fired_q[0]
		&& wt0_count == wrap) else $error("calibration end inconsistent");
	refuse_a: assert property (cal_start && (cal_busy_q || wt_running[0]) |=>
		cal_refused_q && !cal_done) else $error("calibration start not refused");

	cover property (sysctl_irq_q[1]);
	cover property (cal_done);
	cover property (cal_refused_q);
endmodule

bind swt_top swt_props #(.CNT_W(CNT_W)) i_swt_props (
	.core_clk(core_clk), .rst_n(rst_n), .lp_clk(lp_clk), .wt0_start(wt0_start),
	.wt0_stop(wt0_stop), .wt0_int_en(wt0_int_en), .wt1_start(wt1_start),
	.wt1_load(wt1_load), .wt1_stop(wt1_stop), .wt1_int_en(wt1_int_en),
	.fired_rd(fired_rd), .cal_start(cal_start), .wt0_count(wt0_count),
	.wt1_count(wt1_count), .wt_running(wt_running), .wt_fired_q(wt_fired_q),
	.sysctl_irq_q(sysctl_irq_q), .cal_busy_q(cal_busy_q), .cal_done(cal_done),
	.cal_refused_q(cal_refused_q)
);

// file: verif/swt_sysctl_model.sv
`timescale 1ns/1ps

module swt_sysctl_model (
	input  wire       core_clk,      // Core clock.
	input  wire       rst_n,         // Reset, active low.
	input  wire [1:0] sysctl_irq_q,  // Timer event pulses.
	output reg  [7:0] wake_cnt0_q,   // Events from timer zero.
	output reg  [7:0] wake_cnt1_q    // Events from timer one.
);
	// Events share one path, so each pulse is counted as it passes; none is latched.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt0_q <= 8'h00;
			wake_cnt1_q <= 8'h00;
		end else begin
			wake_cnt0_q <= wake_cnt0_q + {7'h00, sysctl_irq_q[0]};
			wake_cnt1_q <= wake_cnt1_q + {7'h00, sysctl_irq_q[1]};
		end
	end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
`include "swt_defs.vh"

module tb;
	reg         core_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         lp_clk = 1'b0;
	reg  [1:0]  ref_div = 2'h0;
	reg  [5:0]  pls = 6'h00;
	reg         wt0_int_en = 1'b0;
	reg         wt1_int_en = 1'b1;
	reg  [40:0] load = 41'h0;
	reg         got_done_q = 1'b0;
	wire [40:0] wt0_count, wt1_count;
	wire [1:0]  wt_running, wt_fired_q, sysctl_irq_q;
	wire        cal_busy_q, cal_done, cal_refused_q;
	wire [31:0] cal_result;
	wire [7:0]  wake_cnt0, wake_cnt1;
	integer     n_errors, checks, i, j;

	// Reference clock is a quarter of the core rate, so each slow period holds two reference periods.
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) ref_div <= ref_div + 2'h1;
	always @(posedge core_clk) got_done_q <= !pls[5] && (got_done_q || cal_done === 1'b1);

	swt_top i_swt_top (
		.core_clk(core_clk), .rst_n(rst_n), .lp_clk(lp_clk), .ref_clk(ref_div[1]),
		.wt0_start(pls[0]), .wt0_load(load), .wt0_stop(pls[1]), .wt0_int_en(wt0_int_en),
		.wt1_start(pls[2]), .wt1_load(load), .wt1_stop(pls[3]), .wt1_int_en(wt1_int_en),
		.fired_rd(pls[4]), .cal_start(pls[5]), .cal_periods(load[15:0]),
		.wt0_count(wt0_count), .wt1_count(wt1_count), .wt_running(wt_running),
		.wt_fired_q(wt_fired_q), .sysctl_irq_q(sysctl_irq_q), .cal_busy_q(cal_busy_q),
		.cal_done(cal_done), .cal_refused_q(cal_refused_q), .cal_result(cal_result)
	);
	swt_sysctl_model i_swt_sysctl_model (
		.core_clk(core_clk), .rst_n(rst_n), .sysctl_irq_q(sysctl_irq_q),
		.wake_cnt0_q(wake_cnt0), .wake_cnt1_q(wake_cnt1)
	);

	task check(input string name, input [40:0] seen, input [40:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	task conclude;
		begin
			if (n_errors == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	// One-cycle pulse on strobe k with the shared value; outputs are settled on return.
	task go(input integer k, input [40:0] v);
		begin
			@(posedge core_clk);
			pls <= 6'h01 << k;
			load <= v;
			@(posedge core_clk);
			pls <= 6'h00;
			#1;
		end
	endtask

	// One slow-clock period of eight core cycles.
	task tick;
		begin
			@(posedge core_clk);
			lp_clk <= 1'b1;
			repeat (4) @(posedge core_clk);
			lp_clk <= 1'b0;
			repeat (3) @(posedge core_clk);
			#1;
		end
	endtask

	task cal_run(input [40:0] p, input [40:0] n);
		begin
			// Timer zero keeps running after a calibration, so stop it first each time.
			go(1, 41'h0);
			go(4, 41'h0);
			go(5, p);
			check("cal busy", cal_busy_q, 1);
			go(5, p);
			check("cal refused", cal_refused_q, 1);
			tick;
			check("cal load", wt0_count, n);
			for (i = 0; i < n; i = i + 1)
				tick;
			for (j = 0; j < 8 && !got_done_q; j = j + 1)
				@(posedge core_clk);
			if (!got_done_q) begin
				n_errors = n_errors + 1;
				conclude;
			end
			check("cal ref", cal_result >= 2 * n - 1 && cal_result <= 2 * n + 1, 1);
			check("cal idle", cal_busy_q, 0);
			check("cal fired", wt_fired_q[0], 1);
		end
	endtask

	initial begin
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check("reset run", wt_running, 0);
		go(2, 41'h2);
		check("wt1 load", wt1_count, 2);
		check("wt1 run", wt_running[1], 1);
		tick;
		check("wt1 dec", wt1_count, 1);
		tick;
		check("wt1 wrap", wt1_count, `SWT_WRAP_VAL);
		check("wt1 fired", wt_fired_q[1], 1);
		check("wake one", wake_cnt1, 1);
		tick;
		check("wt1 live", wt1_count, `SWT_WRAP_VAL - 41'h1);
		go(0, 41'h0);
		tick;
		check("wt0 fired", wt_fired_q[0], 1);
		check("wake zero", wake_cnt0, 0);
		go(4, 41'h0);
		check("fired clr", wt_fired_q, 0);
		go(0, 41'h3);
		tick;
		check("wt0 dec", wt0_count, 2);
		go(5, 41'h0);
		check("busy refuse", cal_refused_q, 1);
		go(1, 41'h0);
		tick;
		tick;
		check("wt0 frozen", wt0_count, 2);
		check("wt0 stopped", wt_running[0], 0);
		check("wt0 no fire", wt_fired_q[0], 0);
		cal_run(41'h0, 41'd20);
		cal_run(41'h5, 41'h5);
		check("cal no irq", wake_cnt0, 0);
		conclude;
	end
endmodule
